// >>> rtl/lcd_cfg_pkg.sv
// constants, field positions and carrier types for the lcd bias/clock block
// assumes a 32-bit apb slave with byte addresses, one register per word
package lcd_cfg_pkg;
    // register byte offsets
    localparam logic [11:0] REF_OFF  = 12'h000;
    localparam logic [11:0] CST_OFF  = 12'h004;
    localparam logic [11:0] CTRL_OFF = 12'h008;
    localparam logic [11:0] STAT_OFF = 12'h00c;
    localparam logic [11:0] SEG_BASE = 12'h010;
    localparam logic [11:0] PIX_BASE = 12'h020;
    localparam int          SEG_REGS = 3;
    localparam int          PIX_REGS = 12;
    // reference control fields
    localparam int REF_IRE = 7;
    localparam int REF_IRS = 6;
    localparam int REF_IRI = 5;
    localparam int REF_P3  = 3;
    localparam int REF_P2  = 2;
    localparam int REF_P1  = 1;
    localparam logic [7:0] REF_MASK  = 8'hee;
    localparam logic [7:0] CST_MASK  = 8'h07;
    localparam logic [7:0] REF_RESET = 8'h00;
    localparam logic [2:0] CST_RESET = 3'h0;
    // display control fields: prescale 3:0, source 5:4, half bias 6, commons 9:8
    localparam int CTRL_PS_LSB  = 0;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_HALF    = 6;
    localparam int CTRL_MUX_LSB = 8;
    localparam logic [3:0] PS_RESET  = 4'h3;
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [1:0] MUX_RESET = 2'h3;
    localparam logic [1:0] MUX_STATIC = 2'h0;
    localparam logic [1:0] MUX_QUAD   = 2'h3;
    // clock source codes
    localparam logic [1:0] SRC_SYS = 2'h0;
    localparam logic [1:0] SRC_SEC = 2'h1;
    localparam int SYS_DIV = 256;
    // status bits
    localparam int ST_RUN = 0;
    localparam int ST_ACT = 1;
    localparam int ST_REF = 2;
    localparam int ST_BUF = 3;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic       ref_on;
        logic       src_fvr;
        logic       src_io;
        logic       fvr_buffer_on;
        logic       contrast_connected;
        logic [2:0] contrast_tap;
        logic       top_bias_pin_connect;
        logic       upper_mid_bias_pin_connect;
        logic       lower_mid_bias_pin_connect;
        logic       ladder_static;
        logic       ladder_half;
    } bias_out_t;
endpackage

// >>> rtl/lcd_clock_gen.sv
// lcd clock source selection, fixed system divider and 4-bit prescaler
// assumes both oscillator inputs are asynchronous square waves far below clk
`timescale 1ns/100ps
`default_nettype none
module lcd_clock_gen
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] src_sel,
    input  wire logic [3:0] prescale,
    input  wire logic       cpu_sleep,
    input  wire logic       sec_osc_pin,
    input  wire logic       lfint_osc_pin,
    output logic            frame_tick,
    output logic            source_running
);
    logic [7:0] sys_cnt_reg;
    logic [2:0] sec_sync_reg;
    logic [2:0] lf_sync_reg;
    logic [3:0] pre_cnt_reg;
    logic       src_tick;
    logic       sys_tick;

    // fixed divide by 256, frozen while the processor sleeps
    always_ff @(posedge clk)
    begin
        if (rst)
            sys_cnt_reg <= 8'h00;
        else if (!cpu_sleep)
            sys_cnt_reg <= sys_cnt_reg + 8'h01; // RULE_13
    end
    assign sys_tick = !cpu_sleep && (sys_cnt_reg == 8'(lcd_cfg_pkg::SYS_DIV - 1)); // RULE_15

    // oscillator pins: two flops, third flop only for the edge detector
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sec_sync_reg <= 3'h0;
            lf_sync_reg  <= 3'h0;
        end
        else
        begin
            sec_sync_reg <= {sec_sync_reg[1:0], sec_osc_pin};
            lf_sync_reg  <= {lf_sync_reg[1:0], lfint_osc_pin};
        end
    end

    // source mux; oscillator sources keep running in sleep
    always_comb
    begin
        if (src_sel == lcd_cfg_pkg::SRC_SYS)
            src_tick = sys_tick; // RULE_11 RULE_12
        else if (src_sel == lcd_cfg_pkg::SRC_SEC)
            src_tick = sec_sync_reg[1] && !sec_sync_reg[2]; // RULE_12
        else
            src_tick = lf_sync_reg[1] && !lf_sync_reg[2]; // RULE_12 RULE_15
    end

    // prescaler: divide by prescale+1; >= guards a ratio lowered mid-count
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pre_cnt_reg <= 4'h0;
            frame_tick  <= 1'b0;
        end
        else
        begin
            frame_tick <= 1'b0;
            if (src_tick)
            begin
                if (pre_cnt_reg >= prescale) // RULE_16 RULE_17
                begin
                    pre_cnt_reg <= 4'h0;
                    frame_tick  <= 1'b1;
                end
                else
                    pre_cnt_reg <= pre_cnt_reg + 4'h1;
            end
        end
    end

    // running flag for status: sources that survive sleep
    always_ff @(posedge clk)
    begin
        if (rst)
            source_running <= 1'b0;
        else
            source_running <= !(cpu_sleep && src_sel == lcd_cfg_pkg::SRC_SYS);
    end

    a_sleep_stops_sys: assert property (@(posedge clk) disable iff (rst) // RULE_15
        (cpu_sleep && src_sel == lcd_cfg_pkg::SRC_SYS) |-> !src_tick)
        else $error("system divided source ticked during sleep");
    a_prescale_unity: assert property (@(posedge clk) disable iff (rst) // RULE_17
        (prescale == 4'h0 && src_tick) |=> frame_tick)
        else $error("ratio 1:1 did not pass a source tick");
    a_sys_div_period: assert property (@(posedge clk) disable iff (rst) // RULE_13
        (sys_tick && !cpu_sleep) |=> !sys_tick [*8])
        else $error("divided system source ticked too soon");
endmodule
`default_nettype wire

// >>> rtl/lcd_bias_ctrl.sv
// reference, buffer, contrast and bias pin steering from the control bits
// assumes module_active and ladder_mode_b come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module lcd_bias_ctrl
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [7:0]            ref_ctrl,
    input  wire logic [2:0]            contrast_field,
    input  wire logic [1:0]            commons,
    input  wire logic                  half_bias,
    input  wire logic                  module_active,
    input  wire logic                  ladder_mode_b,
    output lcd_cfg_pkg::bias_out_t     bias_out
);
    logic ref_on;

    // inactive module forces the reference off whatever the enable says
    assign ref_on = ref_ctrl[lcd_cfg_pkg::REF_IRE] && module_active; // RULE_01 RULE_20

    // all analog steering registered; pin direction controls are not touched here
    always_ff @(posedge clk)
    begin
        if (rst)
            bias_out <= '0;
        else
        begin
            bias_out.ref_on  <= ref_on; // RULE_01
            bias_out.src_fvr <= ref_on && ref_ctrl[lcd_cfg_pkg::REF_IRS]; // RULE_02
            bias_out.src_io  <= ref_on && !ref_ctrl[lcd_cfg_pkg::REF_IRS]; // RULE_03
            bias_out.fvr_buffer_on <= ref_on && ref_ctrl[lcd_cfg_pkg::REF_IRS]
                && !(ref_ctrl[lcd_cfg_pkg::REF_IRI] && ladder_mode_b); // RULE_04 RULE_05
            bias_out.contrast_connected <= ref_on; // RULE_04
            bias_out.contrast_tap <= ref_on ? contrast_field : 3'h0; // RULE_08
            // pin links are independent of the internal reference
            bias_out.top_bias_pin_connect <= ref_ctrl[lcd_cfg_pkg::REF_P3]; // RULE_06 RULE_07 RULE_19
            bias_out.upper_mid_bias_pin_connect <= ref_ctrl[lcd_cfg_pkg::REF_P2]; // RULE_06
            bias_out.lower_mid_bias_pin_connect <= ref_ctrl[lcd_cfg_pkg::REF_P1]; // RULE_06
            // static: two levels, half: middle resistor shorted, else four levels
            bias_out.ladder_static <= commons == lcd_cfg_pkg::MUX_STATIC; // RULE_18
            bias_out.ladder_half <= commons != lcd_cfg_pkg::MUX_STATIC
                && commons != lcd_cfg_pkg::MUX_QUAD && half_bias; // RULE_18
        end
    end

    a_ref_off_idle: assert property (@(posedge clk) disable iff (rst) // RULE_20
        !module_active |=> !bias_out.ref_on && !bias_out.contrast_connected)
        else $error("reference stayed on while module inactive");
    a_buffer_gate: assert property (@(posedge clk) disable iff (rst) // RULE_05
        (ref_ctrl[lcd_cfg_pkg::REF_IRI] && ladder_mode_b) |=> !bias_out.fvr_buffer_on)
        else $error("reference buffer on in idle mode b");
    a_source_exclusive: assert property (@(posedge clk) disable iff (rst) // RULE_03
        (ref_on && !ref_ctrl[lcd_cfg_pkg::REF_IRS]) |=> bias_out.src_io && !bias_out.src_fvr)
        else $error("io rail source not chosen");
endmodule
`default_nettype wire

// >>> rtl/lcd_bias_clock_config.sv
// top of the lcd bias and clock configuration block with its apb register file
// assumes apb master on clk; oscillator pins asynchronous; sleep and active on clk
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RULE_01] reference enable bit 7 turns the internal reference on and feeds contrast.
// [RULE_02] source bit 6 set powers contrast from the fixed reference output.
// [RULE_03] source bit clear powers contrast from the io supply rail.
// [RULE_04] enable clear leaves contrast unconnected and its buffer disabled.
// [RULE_05] idle bit 5 with ladder in mode b disables the reference buffer.
// [RULE_06] bits 3,2,1 each connect one external bias pin to its level.
// [RULE_07] bias pin links never change pin direction or analog select.
// [RULE_08] 3-bit contrast code n sets ladder to n/7 of full resistance.
// [RULE_09] segment enable bit set gives the pin to lcd, clear to io.
// [RULE_10] pixel bit set means dark; contents are not reset.
// [RULE_11] three clock sources chosen by a 2-bit field.
// [RULE_12] code 00 system/256, 01 secondary crystal, 1x low-frequency oscillator.
// [RULE_13] the divide by 256 is fixed; only the prescaler adjusts rate.
// [RULE_14] software should enable the secondary oscillator before selecting it.
// [RULE_15] oscillator sources run in sleep; divided system source stops.
// [RULE_16] 4-bit hidden prescale counter, ratio 1:1 to 1:16.
// [RULE_17] prescale value n divides by n+1.
// [RULE_18] static, half and third bias with two, three, four levels.
// [RULE_19] internal contrast and ladder may be used with external bias pins.
// [RULE_20] inactive module forces the internal reference off.
// [RULE_21] unimplemented reference and contrast bits read zero, ignore writes.
module lcd_bias_clock_config
#(
    parameter int SEG_REGS = lcd_cfg_pkg::SEG_REGS,
    parameter int PIX_REGS = lcd_cfg_pkg::PIX_REGS
)
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire lcd_cfg_pkg::apb_req_t apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  cpu_sleep,
    input  wire logic                  module_active_flag,
    input  wire logic                  ladder_mode_b,
    input  wire logic                  secondary_crystal_oscillator,
    input  wire logic                  low_freq_internal_oscillator,
    output lcd_cfg_pkg::bias_out_t     bias_out,
    output logic                       frame_tick,
    output logic [8*SEG_REGS-1:0]      segment_pin_enable_bit,
    output logic [8*PIX_REGS-1:0]      pixel_on_bit
);
    logic [7:0]            ref_reg;
    logic [2:0]            cst_reg;
    logic [3:0]            prescale_select;
    logic [1:0]            clk_src_reg;
    logic                  half_bias_reg;
    logic [1:0]            commons_reg;
    logic [7:0]            seg_reg [SEG_REGS];
    logic [7:0]            pix_mem [PIX_REGS];
    logic                  source_running;
    logic                  access;
    logic                  wr_en;
    logic [31:0]           rd_next;
    logic                  err_next;
    int                    seg_idx;
    int                    pix_idx;

    // index of a word inside a register bank, or -1 when outside it
    function automatic int bank_index(input logic [11:0] addr,
                                      input logic [11:0] base,
                                      input int          count);
        int idx;
        idx = -1;
        if (addr[1:0] == 2'h0 && addr >= base && addr < base + 12'(4 * count))
            idx = int'((addr - base) >> 2);
        return idx;
    endfunction

    // bank decode shared by the read mux and both write banks
    assign seg_idx = bank_index(apb_req.paddr, lcd_cfg_pkg::SEG_BASE, SEG_REGS);
    assign pix_idx = bank_index(apb_req.paddr, lcd_cfg_pkg::PIX_BASE, PIX_REGS);

    // first access cycle samples, second completes: one wait state per transfer
    assign access = apb_req.psel && apb_req.penable;
    assign wr_en  = access && pready && apb_req.pwrite;

    // ready pulses for one cycle, but a request held on after ready completes again two cycles later
    always_ff @(posedge clk)
    begin
        if (rst)
            pready <= 1'b0;
        else
            pready <= access && !pready;
    end

    // read mux and unmapped decode
    always_comb
    begin
        rd_next  = 32'h0000_0000;
        err_next = 1'b0;
        case (apb_req.paddr)
            lcd_cfg_pkg::REF_OFF:
                rd_next[7:0] = ref_reg & lcd_cfg_pkg::REF_MASK; // RULE_21
            lcd_cfg_pkg::CST_OFF:
                rd_next[2:0] = cst_reg; // RULE_21
            lcd_cfg_pkg::CTRL_OFF:
            begin
                rd_next[lcd_cfg_pkg::CTRL_PS_LSB +: 4]  = prescale_select;
                rd_next[lcd_cfg_pkg::CTRL_SRC_LSB +: 2] = clk_src_reg;
                rd_next[lcd_cfg_pkg::CTRL_HALF]         = half_bias_reg;
                rd_next[lcd_cfg_pkg::CTRL_MUX_LSB +: 2] = commons_reg;
            end
            lcd_cfg_pkg::STAT_OFF:
            begin
                rd_next[lcd_cfg_pkg::ST_RUN] = source_running;
                rd_next[lcd_cfg_pkg::ST_ACT] = module_active_flag;
                rd_next[lcd_cfg_pkg::ST_REF] = bias_out.ref_on;
                rd_next[lcd_cfg_pkg::ST_BUF] = bias_out.fvr_buffer_on;
            end
            default:
            begin
                if (seg_idx >= 0)
                    rd_next[7:0] = seg_reg[seg_idx];
                else if (pix_idx >= 0)
                    rd_next[7:0] = pix_mem[pix_idx];
                else
                    err_next = 1'b1;
            end
        endcase
    end

    // read data and error held with ready; zero otherwise
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (access && !pready)
        begin
            prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_next;
            pslverr <= err_next;
        end
        else
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // reference and contrast registers; unimplemented bits never stored
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ref_reg <= lcd_cfg_pkg::REF_RESET;
            cst_reg <= lcd_cfg_pkg::CST_RESET;
        end
        else if (wr_en && apb_req.paddr == lcd_cfg_pkg::REF_OFF)
            ref_reg <= apb_req.pwdata[7:0] & lcd_cfg_pkg::REF_MASK; // RULE_21
        else if (wr_en && apb_req.paddr == lcd_cfg_pkg::CST_OFF)
            cst_reg <= apb_req.pwdata[2:0]; // RULE_08 RULE_21
    end

    // display control: source, prescale, commons and bias choice
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prescale_select <= lcd_cfg_pkg::PS_RESET;
            clk_src_reg     <= lcd_cfg_pkg::SRC_RESET;
            half_bias_reg   <= 1'b0;
            commons_reg     <= lcd_cfg_pkg::MUX_RESET;
        end
        else if (wr_en && apb_req.paddr == lcd_cfg_pkg::CTRL_OFF)
        begin
            prescale_select <= apb_req.pwdata[lcd_cfg_pkg::CTRL_PS_LSB +: 4]; // RULE_16
            clk_src_reg     <= apb_req.pwdata[lcd_cfg_pkg::CTRL_SRC_LSB +: 2]; // RULE_11
            half_bias_reg   <= apb_req.pwdata[lcd_cfg_pkg::CTRL_HALF]; // RULE_18
            commons_reg     <= apb_req.pwdata[lcd_cfg_pkg::CTRL_MUX_LSB +: 2];
        end
    end

    // segment enables: pin to lcd when set, to io when clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < SEG_REGS; i++)
                seg_reg[i] <= 8'h00;
        end
        else if (wr_en && seg_idx >= 0)
            seg_reg[seg_idx] <= apb_req.pwdata[7:0]; // RULE_09
    end

    // pixel memory deliberately has no reset: contents survive any reset
    always_ff @(posedge clk)
    begin
        if (wr_en && pix_idx >= 0)
            pix_mem[pix_idx] <= apb_req.pwdata[7:0]; // RULE_10
    end

    // flatten banks to pins; bit set means lcd function / dark pixel
    always_comb
    begin
        for (int i = 0; i < SEG_REGS; i++)
            segment_pin_enable_bit[8*i +: 8] = seg_reg[i]; // RULE_09
        for (int i = 0; i < PIX_REGS; i++)
            pixel_on_bit[8*i +: 8] = pix_mem[i]; // RULE_10
    end

    // software must start the secondary oscillator itself; no check made here
    lcd_clock_gen u_clock
    (
        .clk            (clk),
        .rst            (rst),
        .src_sel        (clk_src_reg),
        .prescale       (prescale_select),
        .cpu_sleep      (cpu_sleep),
        .sec_osc_pin    (secondary_crystal_oscillator),
        .lfint_osc_pin  (low_freq_internal_oscillator),
        .frame_tick     (frame_tick),
        .source_running (source_running)
    );

    lcd_bias_ctrl u_bias
    (
        .clk            (clk),
        .rst            (rst),
        .ref_ctrl       (ref_reg),
        .contrast_field (cst_reg),
        .commons        (commons_reg),
        .half_bias      (half_bias_reg),
        .module_active  (module_active_flag),
        .ladder_mode_b  (ladder_mode_b),
        .bias_out       (bias_out)
    );

    a_ref_read_zero: assert property (@(posedge clk) disable iff (rst) // RULE_21
        (pready && !apb_req.pwrite && apb_req.paddr == lcd_cfg_pkg::REF_OFF)
        |-> (prdata[4] == 1'b0 && prdata[0] == 1'b0))
        else $error("unimplemented reference bit read nonzero");
    a_cst_write: assert property (@(posedge clk) disable iff (rst) // RULE_08
        (wr_en && apb_req.paddr == lcd_cfg_pkg::CST_OFF)
        |=> cst_reg == $past(apb_req.pwdata[2:0]))
        else $error("contrast write not stored");
    a_ready_single: assert property (@(posedge clk) disable iff (rst)
        pready |=> !pready)
        else $error("ready held two cycles");
    a_ref_enable_follow: assert property (@(posedge clk) disable iff (rst) // RULE_01
        (ref_reg[lcd_cfg_pkg::REF_IRE] && module_active_flag) [*2] |-> bias_out.ref_on)
        else $error("reference not on while enabled and active");
    a_pin_follow: assert property (@(posedge clk) disable iff (rst) // RULE_06
        $changed(ref_reg[lcd_cfg_pkg::REF_P3])
        |=> bias_out.top_bias_pin_connect == $past(ref_reg[lcd_cfg_pkg::REF_P3]))
        else $error("top bias pin link does not follow its bit");

    // bank and control writes show up one cycle after they land
    a_seg_write: assert property (@(posedge clk) disable iff (rst) // RULE_09
        (wr_en && apb_req.paddr == lcd_cfg_pkg::SEG_BASE)
        |=> segment_pin_enable_bit[7:0] == $past(apb_req.pwdata[7:0]))
        else $error("segment enable write lost");

    a_pixel_write: assert property (@(posedge clk) disable iff (rst) // RULE_10
        (wr_en && apb_req.paddr == lcd_cfg_pkg::PIX_BASE)
        |=> pixel_on_bit[7:0] == $past(apb_req.pwdata[7:0]))
        else $error("pixel write lost");

    a_ctrl_write: assert property (@(posedge clk) disable iff (rst) // RULE_16
        (wr_en && apb_req.paddr == lcd_cfg_pkg::CTRL_OFF)
        |=> prescale_select == $past(apb_req.pwdata[lcd_cfg_pkg::CTRL_PS_LSB +: 4]))
        else $error("prescale write lost");

    // a refused or idle cycle must never leak read data
    a_err_no_data: assert property (@(posedge clk) disable iff (rst)
        pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error response carried data");

    a_idle_quiet: assert property (@(posedge clk) disable iff (rst)
        !pready |-> prdata == 32'h0000_0000 && !pslverr)
        else $error("bus answer outside ready cycle");

    a_cst_read_zero: assert property (@(posedge clk) disable iff (rst) // RULE_21
        (pready && !apb_req.pwrite && apb_req.paddr == lcd_cfg_pkg::CST_OFF)
        |-> prdata[31:3] == 29'h0)
        else $error("unimplemented contrast bit read nonzero");

    // sleep on the divided system source stops frames; oscillators do not
    a_sleep_no_frame: assert property (@(posedge clk) disable iff (rst) // RULE_15
        (cpu_sleep && clk_src_reg == lcd_cfg_pkg::SRC_SYS) |=> !frame_tick)
        else $error("frame tick from system source in sleep");

    a_idle_no_buffer: assert property (@(posedge clk) disable iff (rst) // RULE_20
        !module_active_flag |=> !bias_out.fvr_buffer_on && bias_out.contrast_tap == 3'h0)
        else $error("buffer or contrast live while inactive");

    a_pin_links: assert property (@(posedge clk) disable iff (rst) // RULE_06 RULE_07
        ##1 bias_out.upper_mid_bias_pin_connect == $past(ref_reg[lcd_cfg_pkg::REF_P2])
        && bias_out.lower_mid_bias_pin_connect == $past(ref_reg[lcd_cfg_pkg::REF_P1]))
        else $error("middle bias pin links do not follow bits");

    a_contrast_tap: assert property (@(posedge clk) disable iff (rst) // RULE_08
        (ref_reg[lcd_cfg_pkg::REF_IRE] && module_active_flag)
        |=> bias_out.contrast_tap == $past(cst_reg))
        else $error("contrast tap does not follow field");
endmodule
`default_nettype wire

// >>> tb/lcd_osc_model.sv
// free-running stand-ins for the secondary crystal and the low-frequency oscillator
// assumes 1 ns units; both periods are far slower than the 8 ns core clock
`timescale 1ns/100ps
`default_nettype none
module lcd_osc_model
#(
    parameter int SEC_HALF = 100,
    parameter int LF_HALF  = 150
)
(
    output logic sec_osc,
    output logic lf_osc
);
    // both oscillators keep running whatever the core does, so sleep cannot stop them
    // start 1 ns late so no edge lands on a core clock edge
    initial
    begin
        sec_osc = 1'b0;
        lf_osc  = 1'b0;
        #1;
        fork
            forever #(SEC_HALF) sec_osc = ~sec_osc;
            forever #(LF_HALF) lf_osc = ~lf_osc;
        join
    end
endmodule
`default_nettype wire

// >>> tb/lcd_bias_clock_config_test.sv
// self-checking bench for the lcd bias and clock configuration block
// assumes the block answers apb after one wait state and ticks as noted
`timescale 1ns/100ps
`default_nettype none
module lcd_bias_clock_config_test;
    logic                  clk = 1'b0;
    logic                  rst = 1'b1;
    lcd_cfg_pkg::apb_req_t req = '0;
    logic                  slp = 1'b0;
    logic                  act = 1'b1;
    logic                  mb  = 1'b0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    lcd_cfg_pkg::bias_out_t bo;
    logic                  tick;
    logic [23:0]           seg;
    logic [95:0]           pix;
    logic                  sec;
    logic                  lf;
    int                    failures = 0;
    int                    cmp_count = 0;
    int                    cyc = 0;
    logic [31:0]           q;
    logic                  e;
    int                    n;
    lcd_bias_clock_config i_lcd_bias_clock_config (.clk(clk), .rst(rst), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_sleep(slp),
        .module_active_flag(act), .ladder_mode_b(mb), .secondary_crystal_oscillator(sec),
        .low_freq_internal_oscillator(lf), .bias_out(bo), .frame_tick(tick),
        .segment_pin_enable_bit(seg), .pixel_on_bit(pix));
    lcd_osc_model i_lcd_osc_model (.sec_osc(sec), .lf_osc(lf));
    always #4 clk = ~clk;
    // hang guard: generous over the longest frame measurements
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            failures++;
            summarize();
        end
    end
    task summarize();
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, x, g);
        end
    endtask
    // request held until pready is sampled high, then released
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        req <= '0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("wr_err", 32'h0, {31'h0, e});
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk("rdata", x, q);
    endtask
    // write ref and contrast, then compare the steering against the rules
    task bias(input logic [7:0] v, input logic [2:0] c);
        logic r;
        wr(lcd_cfg_pkg::REF_OFF, {24'h0, v});
        wr(lcd_cfg_pkg::CST_OFF, {29'h0, c});
        repeat (2) @(posedge clk);
        r = v[7] & act;
        chk("bias", {r, r & v[6] & ~(v[5] & mb), r, r ? c : 3'h0, v[3:1], r & v[6], r & ~v[6]},
            {bo.ref_on, bo.fvr_buffer_on, bo.contrast_connected, bo.contrast_tap,
             bo.top_bias_pin_connect, bo.upper_mid_bias_pin_connect,
             bo.lower_mid_bias_pin_connect, bo.src_fvr, bo.src_io});
    endtask
    // commons and half bit pick the ladder shape
    task ladder(input logic [9:0] ctrl, input logic [1:0] x);
        wr(lcd_cfg_pkg::CTRL_OFF, {22'h0, ctrl});
        repeat (2) @(posedge clk);
        chk("ladder", {30'h0, x}, {30'h0, bo.ladder_static, bo.ladder_half});
    endtask
    // cycles between two frame ticks, after one settling interval
    task gap(input logic [9:0] ctrl, input int lo, input int hi);
        wr(lcd_cfg_pkg::CTRL_OFF, {22'h0, ctrl});
        repeat (2)
        begin
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end while (tick !== 1'b1 && n < 5000);
        end
        chk("frame_gap", 32'h1, {31'h0, n >= lo && n <= hi});
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(lcd_cfg_pkg::REF_OFF, 32'h0);
        rd(lcd_cfg_pkg::CTRL_OFF, 32'h303);
        rd(lcd_cfg_pkg::SEG_BASE, 32'h0);
        bias(8'h80, 3'h0);
        bias(8'hc0, 3'h7);
        bias(8'he0, 3'h5);
        mb <= 1'b1;
        bias(8'he0, 3'h5);
        bias(8'h4e, 3'h3);
        bias(8'hca, 3'h1);
        rd(lcd_cfg_pkg::STAT_OFF, 32'hf);
        act <= 1'b0;
        bias(8'hc4, 3'h6);
        act <= 1'b1;
        wr(lcd_cfg_pkg::REF_OFF, 32'hffffffff);
        rd(lcd_cfg_pkg::REF_OFF, 32'hee);
        wr(lcd_cfg_pkg::CST_OFF, 32'hffffffff);
        rd(lcd_cfg_pkg::CST_OFF, 32'h7);
        rd(12'h0fc, 32'h0);
        chk("slverr", 32'h1, {31'h0, e});
        wr(lcd_cfg_pkg::SEG_BASE, 32'ha5);
        wr(12'h014, 32'h5a);
        wr(12'h018, 32'hff);
        wr(lcd_cfg_pkg::PIX_BASE, 32'h3c);
        wr(12'h04c, 32'hc3);
        @(posedge clk);
        chk("seg_en", 32'hff5aa5, {8'h0, seg});
        chk("pixel", 32'hc33c, {16'h0, pix[95:88], pix[7:0]});
        rd(12'h04c, 32'hc3);
        ladder(10'h003, 2'b10);
        ladder(10'h143, 2'b01);
        ladder(10'h343, 2'b00);
        gap(10'h300, 256, 256);
        gap(10'h301, 512, 512);
        gap(10'h312, 73, 77);
        gap(10'h321, 73, 77);
        slp <= 1'b1;
        gap(10'h330, 36, 39);
        wr(lcd_cfg_pkg::CTRL_OFF, 32'h300);
        // a tick launched from the old source may still be in flight
        repeat (2) @(posedge clk);
        n = 0;
        repeat (600)
        begin
            @(posedge clk);
            n += (tick !== 1'b0);
        end
        chk("sleep_ticks", 32'h0, n);
        rd(lcd_cfg_pkg::STAT_OFF, 32'h6);
        summarize();
    end
endmodule
`default_nettype wire
